//--- sar_adc_sequencer_control.sv
// sar converter sequencer with register file, interrupt and checks
//
// Overview of operation
// - All conversion activity stops while standby is requested.
// - A result read at conversion end completes first; new result stored afterwards.
// - A mode or channel write at conversion end wins: no result, no flag.
// - Channel writes leave the conversion-end flag alone; old completion may set it.
// - Sampling lasts about one tenth of the total conversion time.
// - First result after enabling is undefined and marked invalid.
// - Mode or channel writes may leave the result contents undefined.
// - Bits resolve from bit 7 down to 0; result latched, flag raised.
// - Conversions repeat back to back on the channel while enabled.
// - Mode or channel writes restart conversion; clearing enable stops it at once.
// - Time codes select 144, 120, 96, 72, 60 or 48 clock periods.
`default_nettype none
`include "sar_adc_defs.svh"
module sar_adc_sequencer_control #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite register bus
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analog front end
  input wire logic compAbove,
  output logic sampleOn,
  output logic [7:0] tapCode,
  output logic [1:0] chanSel,
  // power and interrupt
  input wire logic standbyReq,
  output logic conversionEndIrq
);
  import sar_adc_pkg::*;
  if (ADDR_W != 8) begin : g_bad_addr
    $error("sar_adc_sequencer_control: ADDR_W must be 8");
  end
  // ========================================================
  // declarations
  reg_wr_t wrReq;
  reg_rd_t rdReq;
  logic [31:0] rdData;
  logic rdErr, wrErr;
  logic compS, standbyS;
  mode_t mode_q;
  logic [1:0] chan_q;
  logic [7:0] result_q, pendRes_q, approx_q, cnt_q, slot_q;
  logic pendValid_q, pendFirst_q, flag_q, firstMark_q, firstPend_q, bitsDone_q;
  logic [1:0] mask_q;
  logic [2:0] bitIdx_q;
  conv_state_t state_q;
  timing_t tim;
  mode_t modeNew;
  logic modeWr, chanWr, cfgWr, rdResult, rdStatus, endConv, startConv;
  logic storeNow, storeFirst, lastSample;
  logic [7:0] storeVal;
  // ========================================================
  // bus slave and input synchronisers
  axil_reg_slave #(.ADDR_W(ADDR_W)) u_bus (
    .mclk(mclk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wrReq(wrReq), .rdReq(rdReq), .rdData(rdData), .rdErr(rdErr), .wrErr(wrErr)
  );
  sync_two_flop #(.WIDTH(2)) u_sync (
    .mclk(mclk), .rst(rst),
    .asyncIn({compAbove, standbyReq}),
    .syncOut({compS, standbyS})
  );
  // ========================================================
  // timing lookup from the time code
  always_comb begin
    case (mode_q.timeSel)
      `TSEL_120: tim = '{total: `TOT_120, sample: `SMP_120, bitLen: `BIT_120};
      `TSEL_96: tim = '{total: `TOT_96, sample: `SMP_96, bitLen: `BIT_96};
      `TSEL_72: tim = '{total: `TOT_72, sample: `SMP_72, bitLen: `BIT_72};
      `TSEL_60: tim = '{total: `TOT_60, sample: `SMP_60, bitLen: `BIT_60};
      `TSEL_48: tim = '{total: `TOT_48, sample: `SMP_48, bitLen: `BIT_48};
      default: tim = '{total: `TOT_144, sample: `SMP_144, bitLen: `BIT_144};
    endcase
  end
  // ========================================================
  // address decode and access strobes
  always_comb begin
    modeWr = 1'b0;
    chanWr = 1'b0;
    wrErr = 1'b0;
    if (!wrReq.valid) begin
      wrErr = 1'b0;
    end else if (wrReq.addr == `OFS_MODE) begin
      modeWr = wrReq.strb[0];
    end else if (wrReq.addr == `OFS_CHAN) begin
      chanWr = wrReq.strb[0];
    end else if (wrReq.addr == `OFS_MASK) begin
      wrErr = 1'b0;
    end else if (wrReq.addr == `OFS_RESULT || wrReq.addr == `OFS_STATUS) begin
      wrErr = 1'b0;
    end else begin
      wrErr = 1'b1;
    end
  end
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    if (rdReq.addr == `OFS_MODE) begin
      rdData[`MODE_EN_BIT] = mode_q.enable;
      rdData[`MODE_TSEL_HI:`MODE_TSEL_LO] = mode_q.timeSel;
    end else if (rdReq.addr == `OFS_CHAN) begin
      rdData[`CHAN_HI:0] = chan_q;
    end else if (rdReq.addr == `OFS_RESULT) begin
      rdData[7:0] = result_q;
    end else if (rdReq.addr == `OFS_STATUS) begin
      rdData[`STAT_END_BIT] = flag_q;
      rdData[`STAT_FIRST_BIT] = firstMark_q;
    end else if (rdReq.addr == `OFS_MASK) begin
      rdData[1:0] = mask_q;
    end else begin
      rdErr = 1'b1;
    end
  end
  assign cfgWr = modeWr || chanWr;
  assign rdResult = rdReq.valid && rdReq.addr == `OFS_RESULT;
  assign rdStatus = rdReq.valid && rdReq.addr == `OFS_STATUS;
  assign modeNew = modeWr ? {wrReq.data[`MODE_EN_BIT],
                             wrReq.data[`MODE_TSEL_HI:`MODE_TSEL_LO]} : mode_q;
  assign endConv = state_q == ST_CONVERT && cnt_q == tim.total - 8'h01;
  assign lastSample = state_q == ST_SAMPLE && cnt_q == tim.sample - 8'h01;
  assign startConv = state_q == ST_IDLE && mode_q.enable && !standbyS;
  // ========================================================
  // control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= `MODE_RST;
      chan_q <= `CHAN_RST;
      mask_q <= `MASK_RST;
    end else begin
      if (modeWr) begin
        mode_q <= modeNew;
      end
      if (chanWr) begin
        chan_q <= wrReq.data[`CHAN_HI:0];
      end
      if (wrReq.valid && wrReq.addr == `OFS_MASK && wrReq.strb[0]) begin
        mask_q <= wrReq.data[1:0];
      end
    end
  end
  // ========================================================
  // sequencer state and cycle counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
    end else if (standbyS) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
    end else if (cfgWr) begin
      state_q <= modeNew.enable ? ST_SAMPLE : ST_IDLE;
      cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startConv) begin
            state_q <= ST_SAMPLE;
          end
          cnt_q <= 8'h00;
        end
        ST_SAMPLE: begin
          cnt_q <= 8'(cnt_q + 8'h01);
          if (lastSample) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (endConv) begin
            state_q <= ST_SAMPLE;
            cnt_q <= 8'h00;
          end else begin
            cnt_q <= 8'(cnt_q + 8'h01);
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= 8'h00;
        end
      endcase
    end
  end
  // ========================================================
  // successive approximation, msb first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      approx_q <= 8'h00;
      bitIdx_q <= 3'h7;
      slot_q <= 8'h00;
      bitsDone_q <= 1'b0;
    end else if (lastSample && !cfgWr && !standbyS) begin
      approx_q <= `APPROX_START;
      bitIdx_q <= 3'h7;
      slot_q <= tim.bitLen - 8'h01;
      bitsDone_q <= 1'b0;
    end else if (state_q == ST_CONVERT && !bitsDone_q) begin
      if (slot_q != 8'h00) begin
        slot_q <= 8'(slot_q - 8'h01);
      end else begin
        approx_q[bitIdx_q] <= compS;
        if (bitIdx_q != 3'h0) begin
          approx_q[3'(bitIdx_q - 3'h1)] <= 1'b1;
          bitIdx_q <= 3'(bitIdx_q - 3'h1);
          slot_q <= tim.bitLen - 8'h01;
        end else begin
          bitsDone_q <= 1'b1;
        end
      end
    end
  end
  // ========================================================
  // first-result marker
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      firstPend_q <= 1'b0;
    end else if ((startConv && !cfgWr) ||
                 (cfgWr && modeNew.enable && state_q == ST_IDLE && !standbyS)) begin
      firstPend_q <= 1'b1;
    end else if (endConv && !cfgWr && !standbyS) begin
      firstPend_q <= 1'b0;
    end
  end
  // ========================================================
  // result store, deferred past a coinciding read
  assign storeNow = (endConv && !cfgWr && !standbyS && !rdResult) || pendValid_q;
  assign storeVal = pendValid_q ? pendRes_q : approx_q;
  assign storeFirst = pendValid_q ? pendFirst_q : firstPend_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pendValid_q <= 1'b0;
      pendRes_q <= 8'h00;
      pendFirst_q <= 1'b0;
    end else begin
      pendValid_q <= endConv && !cfgWr && !standbyS && rdResult;
      pendRes_q <= approx_q;
      pendFirst_q <= firstPend_q;
    end
  end
  // config writes leave the stored result as it was, possibly stale
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_q <= `RESULT_RST;
    end else if (storeNow) begin
      result_q <= storeVal;
    end
  end
  // ========================================================
  // sticky status, read clears, a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
      firstMark_q <= 1'b0;
    end else begin
      if (storeNow) begin
        flag_q <= 1'b1;
      end else if (rdStatus) begin
        flag_q <= 1'b0;
      end
      if (storeNow && storeFirst) begin
        firstMark_q <= 1'b1;
      end else if (rdStatus) begin
        firstMark_q <= 1'b0;
      end
    end
  end
  // ========================================================
  // registered outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conversionEndIrq <= 1'b0;
    end else begin
      conversionEndIrq <= |({firstMark_q, flag_q} & mask_q);
    end
  end
  assign sampleOn = state_q[1];
  assign tapCode = approx_q;
  assign chanSel = chan_q;
  // ========================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_endClean;
    endConv && !cfgWr && !standbyS;
  endsequence
  sequence s_sampleEnd;
    lastSample && !cfgWr && !standbyS;
  endsequence
  chk_standby_stops: assert property (
    standbyS |=> state_q == ST_IDLE ##1 (!standbyS || state_q == ST_IDLE))
    else $error("conversion runs during standby");
  chk_read_first: assert property (
    (s_endClean and rdResult) |=> $stable(result_q) ##1 result_q == $past(approx_q, 2))
    else $error("result store did not follow the read");
  chk_write_wins: assert property (
    (endConv && cfgWr && !pendValid_q) |=> $stable(result_q) && !$rose(flag_q))
    else $error("result stored despite config write");
  chk_chan_flag: assert property (
    (chanWr && flag_q && !rdStatus) |=> flag_q)
    else $error("channel write cleared the end flag");
  chk_sample_len: assert property (
    s_sampleEnd |=> state_q == ST_CONVERT && approx_q == `APPROX_START && cnt_q == tim.sample)
    else $error("sampling phase length wrong");
  chk_first_mark: assert property (
    (startConv && !cfgWr) ##1 (state_q == ST_SAMPLE)[*2] |-> firstPend_q)
    else $error("first result not marked");
  chk_result_latch: assert property (
    (s_endClean and !rdResult) |=> result_q == $past(approx_q) && flag_q)
    else $error("result not latched at conversion end");
  chk_back_to_back: assert property (
    s_endClean |=> state_q == ST_SAMPLE && cnt_q == 8'h00)
    else $error("next conversion did not start at once");
  chk_stop_now: assert property (
    (modeWr && !wrReq.data[`MODE_EN_BIT]) |=> state_q == ST_IDLE)
    else $error("clearing enable did not stop conversion");
  chk_count_bound: assert property (
    state_q == ST_CONVERT |-> cnt_q < tim.total && cnt_q >= tim.sample)
    else $error("conversion counter out of range");
  chk_flag_sticky: assert property (
    (flag_q && !rdStatus) |=> flag_q)
    else $error("end flag dropped without a clear");
endmodule : sar_adc_sequencer_control
`default_nettype wire

//--- sar_adc_defs.svh
// constants for the sar conversion sequencer
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
// ==========================================================
// register byte offsets
`define OFS_MODE 8'h00
`define OFS_CHAN 8'h04
`define OFS_RESULT 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MASK 8'h10
// ==========================================================
// field positions
`define MODE_EN_BIT 7
`define MODE_TSEL_HI 5
`define MODE_TSEL_LO 3
`define CHAN_HI 1
`define STAT_END_BIT 0
`define STAT_FIRST_BIT 1
// ==========================================================
// reset values and the approximation start value
`define MODE_RST 4'h0
`define CHAN_RST 2'h0
`define RESULT_RST 8'h00
`define MASK_RST 2'h0
`define APPROX_START 8'h80
// ==========================================================
// conversion time codes
`define TSEL_144 3'h0
`define TSEL_120 3'h1
`define TSEL_96 3'h2
`define TSEL_72 3'h4
`define TSEL_60 3'h5
`define TSEL_48 3'h6
// ==========================================================
// total, sampling and bit-slot lengths in mclk cycles
`define TOT_144 8'h90
`define TOT_120 8'h78
`define TOT_96 8'h60
`define TOT_72 8'h48
`define TOT_60 8'h3C
`define TOT_48 8'h30
`define SMP_144 8'h0E
`define SMP_120 8'h0C
`define SMP_96 8'h09
`define SMP_72 8'h07
`define SMP_60 8'h06
`define SMP_48 8'h05
`define BIT_144 8'h10
`define BIT_120 8'h0D
`define BIT_96 8'h0A
`define BIT_72 8'h08
`define BIT_60 8'h06
`define BIT_48 8'h05
// ==========================================================
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- sar_adc_pkg.sv
// types shared by the sar conversion sequencer
`default_nettype none
package sar_adc_pkg;
  // ========================================================
  // mode register contents
  typedef struct packed {
    logic enable;
    logic [2:0] timeSel;
  } mode_t;
  // ========================================================
  // cycle counts for one conversion
  typedef struct packed {
    logic [7:0] total;
    logic [7:0] sample;
    logic [7:0] bitLen;
  } timing_t;
  // ========================================================
  // register access strobes from the bus slave
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } reg_rd_t;
  // ========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONVERT = 3'h4
  } conv_state_t;
endpackage : sar_adc_pkg
`default_nettype wire

//--- sync_two_flop.sv
// two-flop synchroniser, one per bit
`default_nettype none
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  if (WIDTH < 1) begin : g_bad_width
    $error("sync_two_flop: WIDTH must be at least 1");
  end
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic stable_q;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b0;
        stable_q <= 1'b0;
      end else begin
        meta_q <= asyncIn[i];
        stable_q <= meta_q;
      end
    end
    assign syncOut[i] = stable_q;
  end
endmodule : sync_two_flop
`default_nettype wire

//--- axil_reg_slave.sv
// axi4-lite slave turning bus accesses into register strobes
`default_nettype none
`include "sar_adc_defs.svh"
module axil_reg_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  output sar_adc_pkg::reg_wr_t wrReq,
  output sar_adc_pkg::reg_rd_t rdReq,
  input wire logic [31:0] rdData,
  input wire logic rdErr,
  input wire logic wrErr
);
  import sar_adc_pkg::*;
  if (ADDR_W != 8) begin : g_bad_addr
    $error("axil_reg_slave: ADDR_W must be 8");
  end
  logic awHeld_q, wHeld_q, wrValid_q, rdValid_q;
  logic [7:0] awAddr_q, arAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  // ========================================================
  // write address and data, taken in either order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (bvalid && bready) begin
      awHeld_q <= 1'b0;
      awready <= 1'b1;
    end else if (!awHeld_q) begin
      awready <= 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wready <= 1'b0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (bvalid && bready) begin
      wHeld_q <= 1'b0;
      wready <= 1'b1;
    end else if (!wHeld_q) begin
      wready <= 1'b1;
    end
  end
  // ========================================================
  // write strobe and response
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrValid_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      wrValid_q <= awHeld_q && wHeld_q && !bvalid && !wrValid_q;
      if (wrValid_q) begin
        bvalid <= 1'b1;
        bresp <= wrErr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ========================================================
  // read address, strobe and data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rdValid_q <= 1'b0;
      arAddr_q <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      rdValid_q <= arvalid && arready;
      if (arvalid && arready) begin
        arready <= 1'b0;
        arAddr_q <= araddr;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid && !rdValid_q && !arready) begin
        arready <= 1'b1;
      end
      if (rdValid_q) begin
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end
  assign wrReq = '{valid: wrValid_q, addr: awAddr_q, data: wData_q, strb: wStrb_q};
  assign rdReq = '{valid: rdValid_q, addr: arAddr_q};
endmodule : axil_reg_slave
`default_nettype wire

//--- sar_adc_sequencer_control_test.sv
// self-checking bench for the sar conversion sequencer
`default_nettype none
`include "sar_adc_defs.svh"
module sar_adc_sequencer_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_adc_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, compAbove, sampleOn, standbyReq, irq, prevSmp;
  logic [7:0] awaddr, araddr, tapCode, vin;
  logic [31:0] wdata, rdata, seed, r, c0, lastPeriod, lastSample, periodCnt, smpCnt, rises;
  logic [15:0] t;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, chanSel, resp;
  logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
  int badCount, checksDone;
  sar_adc_sequencer_control sar_adc_sequencer_control_i (.mclk(mclk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .compAbove(compAbove), .sampleOn(sampleOn),
    .tapCode(tapCode), .chanSel(chanSel), .standbyReq(standbyReq), .conversionEndIrq(irq));
  always #20 mclk = ~mclk;
  // comparator: high while the input is at or above the trial tap
  always @(posedge mclk) compAbove <= (vin >= tapCode);
  // ==========================================================
  // sampling and period monitor
  always @(posedge mclk) begin
    periodCnt <= periodCnt + 1;
    if (sampleOn) smpCnt <= smpCnt + 1;
    if (sampleOn && !prevSmp) begin
      lastPeriod <= periodCnt;
      periodCnt <= 32'h1;
      smpCnt <= 32'h1;
      rises <= rises + 1;
    end
    if (!sampleOn && prevSmp) lastSample <= smpCnt;
    prevSmp <= sampleOn;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h0);
  endfunction : lfsr
  function automatic logic [15:0] expTime(input logic [2:0] c);
    case (c)
      3'h1: return {8'h78, 8'h0C};
      3'h2: return {8'h60, 8'h09};
      3'h4: return {8'h48, 8'h07};
      3'h5: return {8'h3C, 8'h06};
      3'h6: return {8'h30, 8'h05};
      default: return {8'h90, 8'h0E};
    endcase
  endfunction : expTime
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 2000) begin
      badCount++;
      $display("[ERR] wait expected done seen timeout");
      results();
    end
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    r = rdata;
    resp = rresp;
  endtask : rd
  task automatic waitIrq(input logic lv);
    int n;
    n = 0;
    while (irq !== lv) tick(n);
  endtask : waitIrq
  // ==========================================================
  // main sequence
  initial begin
    {mclk, awvalid, wvalid, bready, arvalid, rready, standbyReq, prevSmp} = '0;
    {awaddr, araddr, wdata, vin, periodCnt, smpCnt, rises} = '0;
    {lastPeriod, lastSample} = '0;
    wstrb = 4'hF;
    rst = 1'b1;
    seed = 32'h00015D7D;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4));
      check("reset value", 32'h0, r);
      check("read resp", (a == 5) ? 32'h2 : 32'h0, {30'h0, resp});
    end
    wr(`OFS_RESULT, 32'hFF);
    rd(`OFS_RESULT);
    check("result read-only", 32'h0, r);
    wr(8'h14, 32'hFF);
    check("write resp", 32'h2, {30'h0, resp});
    wr(`OFS_MASK, 32'h3);
    foreach (codes[i]) begin
      seed = lfsr(seed);
      vin = seed[7:0];
      wr(`OFS_MODE, 32'h0);
      rd(`OFS_STATUS);
      c0 = rises;
      repeat (100) @(posedge mclk);
      check("stopped", c0, rises);
      wr(`OFS_CHAN, {30'h0, seed[9:8]});
      check("channel", {30'h0, seed[9:8]}, {30'h0, chanSel});
      wr(`OFS_MODE, {24'h0, 2'h2, codes[i], 3'h0});
      waitIrq(1'b1);
      rd(`OFS_STATUS);
      check("first status", 32'h3, r);
      waitIrq(1'b0);
      waitIrq(1'b1);
      rd(`OFS_RESULT);
      check("result", {24'h0, vin}, r);
      rd(`OFS_STATUS);
      check("status", 32'h1, r);
      t = expTime(codes[i]);
      check("period", {24'h0, t[15:8]}, lastPeriod);
      check("sampling", {24'h0, t[7:0]}, lastSample);
    end
    // result read landing on the conversion end edge
    waitIrq(1'b0);
    waitIrq(1'b1);
    c0 = {24'h0, vin};
    vin = ~vin;
    repeat (140) @(posedge mclk);
    rd(`OFS_RESULT);
    check("read first", c0, r);
    rd(`OFS_RESULT);
    check("stored after read", {24'h0, vin}, r);
    // mode write landing on the conversion end edge
    rd(`OFS_STATUS);
    waitIrq(1'b0);
    waitIrq(1'b1);
    rd(`OFS_STATUS);
    c0 = {24'h0, vin};
    vin = ~vin;
    repeat (136) @(posedge mclk);
    wr(`OFS_MODE, 32'h98);
    rd(`OFS_STATUS);
    check("write wins flag", 32'h0, r);
    rd(`OFS_RESULT);
    check("write wins result", c0, r);
    waitIrq(1'b1);
    wr(`OFS_CHAN, 32'h2);
    rd(`OFS_STATUS);
    check("flag kept", 32'h1, r);
    wr(`OFS_MASK, 32'h0);
    rd(`OFS_STATUS);
    c0 = '0;
    repeat (400) begin
      @(posedge mclk);
      if (irq !== 1'b0) c0++;
    end
    check("masked irq", 32'h0, c0);
    rd(`OFS_STATUS);
    check("masked flag", 32'h1, r);
    wr(`OFS_MASK, 32'h3);
    standbyReq <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(`OFS_STATUS);
    c0 = rises;
    repeat (300) @(posedge mclk);
    check("standby runs", c0, rises);
    rd(`OFS_STATUS);
    check("standby flag", 32'h0, r);
    standbyReq <= 1'b0;
    waitIrq(1'b1);
    rd(`OFS_STATUS);
    check("resume status", 32'h3, r);
    wr(`OFS_MODE, 32'h0);
    results();
  end
endmodule : sar_adc_sequencer_control_test
`default_nettype wire
